// ---- design/mfp_motor_fault_protection.v ----
// Purpose: Fault supervision for a three-phase predriver
// Assumes: Comparator inputs already synchronous to clk
// Notes: Supply reset threshold acts as a second asynchronous reset
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mfp_consts.vh"

module mfp_motor_fault_protection #(
	parameter OC_RETRY_CYC = `MFP_OC_RETRY_CYC,
	parameter LONG_RETRY_CYC = `MFP_LONG_RETRY_CYC,
	parameter NUM_FET = 6
) (
	input wire clk,
	input wire nrst,
	input wire supplyResetLow,
	input wire [2:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [15:0] regRdData,
	input wire supplyUnder,
	input wire supplyOverLevel0,
	input wire supplyOverLevel1,
	input wire [NUM_FET-1:0] fetDropHigh0,
	input wire [NUM_FET-1:0] fetDropHigh1,
	input wire [NUM_FET-1:0] fetDropHigh2,
	input wire [NUM_FET-1:0] fetDropHigh3,
	input wire [NUM_FET-1:0] fetEnabled,
	input wire senseOverCur,
	input wire pumpLow,
	input wire pumpShort,
	input wire dieOverTemp,
	output wire faultFlagOutO,
	output wire faultFlagOutOe,
	output wire driverEnable,
	output wire pumpEnable,
	output wire syncRectifyActive
);

	// ==================================================================
	// Reset: pin or supply below reset threshold
	wire rstN;
	assign rstN = nrst & ~supplyResetLow;

	// ==================================================================
	// Registers
	reg [5:0] faultFlag_q;
	reg [6:0] ctrl_q;
	wire syncRectifyEn;
	wire overvoltLevelSel;
	wire retryEn;
	wire [1:0] fetDropLimitSel;
	wire [1:0] overcurrentFilterTime;
	assign syncRectifyEn = ctrl_q[`MFP_CTL_SYNCRECT];
	assign overvoltLevelSel = ctrl_q[`MFP_CTL_OVLEVEL];
	assign retryEn = ctrl_q[`MFP_CTL_RETRY];
	assign fetDropLimitSel = ctrl_q[`MFP_CTL_DROPLIM_HI:`MFP_CTL_DROPLIM_LO];
	assign overcurrentFilterTime = ctrl_q[`MFP_CTL_FILT_HI:`MFP_CTL_FILT_LO];

	// ==================================================================
	// Overvoltage and resync delay
	// Resync delay held as an integer so the counter width is cut on purpose
	localparam integer OV_RESYNC_CYC = `MFP_OV_RESYNC_CYC;
	wire ovEvent;
	reg [11:0] ovCnt_q;
	reg ovHold_q;
	assign ovEvent = overvoltLevelSel ? supplyOverLevel1 : supplyOverLevel0;

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ovHold_q <= 1'b0;
			ovCnt_q <= 12'h000;
		end else if (ovEvent) begin
			ovHold_q <= 1'b1;
			ovCnt_q <= 12'h000;
		end else if (ovHold_q) begin
			if (ovCnt_q >= OV_RESYNC_CYC[11:0] - 12'h001) begin
				ovHold_q <= 1'b0;
			end
			ovCnt_q <= ovCnt_q + 12'h001;
		end
	end
	// Async rectification held while over, then for the resync delay
	assign syncRectifyActive = syncRectifyEn & ~ovEvent & ~ovHold_q;

	// ==================================================================
	// Overcurrent detection with per-FET deglitch
	function [7:0] filtCycles;
		input [1:0] sel;
		begin
			case (sel)
				2'd0: filtCycles = 8'd`MFP_FILT_CYC0;
				2'd1: filtCycles = 8'd`MFP_FILT_CYC1;
				2'd2: filtCycles = 8'd`MFP_FILT_CYC2;
				default: filtCycles = 8'd`MFP_FILT_CYC3;
			endcase
		end
	endfunction

	wire [7:0] filtLimit;
	wire [NUM_FET-1:0] fetTrip;
	assign filtLimit = filtCycles(overcurrentFilterTime);

	genvar g;
	generate
		for (g = 0; g < NUM_FET; g = g + 1) begin : fetMon
			reg [7:0] cnt_q;
			wire over;
			assign over = fetEnabled[g] & ((fetDropLimitSel == 2'd0) ? fetDropHigh0[g] :
				(fetDropLimitSel == 2'd1) ? fetDropHigh1[g] :
				(fetDropLimitSel == 2'd2) ? fetDropHigh2[g] : fetDropHigh3[g]);
			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					cnt_q <= 8'h00;
				end else if (!over) begin
					cnt_q <= 8'h00;
				end else if (cnt_q <= filtLimit) begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
			assign fetTrip[g] = over & (cnt_q >= filtLimit);
		end
	endgenerate

	wire ocEvent;
	assign ocEvent = (|fetTrip) | senseOverCur;

	// ==================================================================
	// Retry timers
	reg [22:0] ocCnt_q;
	reg ocHold_q;
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ocHold_q <= 1'b0;
			ocCnt_q <= 23'h000000;
		end else if (ocEvent && !ocHold_q) begin
			ocHold_q <= 1'b1;
			ocCnt_q <= 23'h000000;
		end else if (ocHold_q) begin
			if (ocCnt_q >= OC_RETRY_CYC[22:0] - 23'h000001) begin
				ocHold_q <= 1'b0;
			end
			ocCnt_q <= ocCnt_q + 23'h000001;
		end
	end

	// Short retry: pump off for the whole hold, then a fresh look
	reg [27:0] scCnt_q;
	reg scHold_q;
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			scHold_q <= 1'b0;
			scCnt_q <= 28'h0000000;
		end else if (pumpShort && !scHold_q) begin
			scHold_q <= 1'b1;
			scCnt_q <= 28'h0000000;
		end else if (scHold_q) begin
			if (scCnt_q >= LONG_RETRY_CYC[27:0] - 28'h0000001) begin
				scHold_q <= 1'b0;
			end
			scCnt_q <= scCnt_q + 28'h0000001;
		end
	end

	// Overtemperature: states
	localparam OT_RUN = 2'b00;
	localparam OT_HOT = 2'b01;
	localparam OT_WAIT = 2'b10;
	localparam OT_LATCH = 2'b11;
	reg [1:0] otState_q;
	reg [27:0] otCnt_q;
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			otState_q <= OT_RUN;
			otCnt_q <= 28'h0000000;
		end else begin
			case (otState_q)
				OT_RUN: begin
					if (dieOverTemp) begin
						otState_q <= OT_HOT;
					end
				end
				OT_HOT: begin
					otCnt_q <= 28'h0000000;
					if (!dieOverTemp) begin
						otState_q <= retryEn ? OT_WAIT : OT_LATCH;
					end
				end
				OT_WAIT: begin
					if (dieOverTemp) begin
						otState_q <= OT_HOT;
					end else if (otCnt_q >= LONG_RETRY_CYC[27:0] - 28'h0000001) begin
						otState_q <= OT_RUN;
					end else begin
						otCnt_q <= otCnt_q + 28'h0000001;
					end
				end
				OT_LATCH: begin
					otState_q <= OT_LATCH;
				end
				default: begin
					otState_q <= OT_RUN;
				end
			endcase
		end
	end
	wire otActive;
	assign otActive = (otState_q != OT_RUN);

	// ==================================================================
	// Outputs
	wire anyFault;
	assign anyFault = supplyUnder | ovEvent | ocHold_q | ocEvent | pumpLow |
		scHold_q | pumpShort | otActive;
	assign faultFlagOutO = 1'b0;
	assign faultFlagOutOe = anyFault;
	assign driverEnable = ~(supplyUnder | ocEvent | ocHold_q | pumpLow |
		pumpShort | scHold_q | otActive);
	assign pumpEnable = ~(pumpShort | scHold_q | otActive);

	// ==================================================================
	// Register port, live during lockout
	wire [5:0] faultSet;
	assign faultSet = {otState_q == OT_HOT, pumpShort, pumpLow, ocEvent, ovEvent,
		supplyUnder};
	wire faultWr;
	wire ctrlWr;
	assign faultWr = regWrStb && (regAddr == `MFP_REG_FAULT);
	assign ctrlWr = regWrStb && (regAddr == `MFP_REG_CTRL);

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			faultFlag_q <= `MFP_FLT_RESET;
			ctrl_q <= `MFP_CTL_RESET;
		end else begin
			// Set wins over a simultaneous clear; writing 1 keeps the bit
			if (faultWr) begin
				faultFlag_q <= (faultFlag_q & regWrData[5:0]) | faultSet;
			end else begin
				faultFlag_q <= faultFlag_q | faultSet;
			end
			if (ctrlWr) begin
				ctrl_q <= regWrData[6:0];
			end
		end
	end

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			regRdData <= 16'h0000;
		end else if (regRdStb) begin
			case (regAddr)
				`MFP_REG_FAULT: regRdData <= {10'h000, faultFlag_q};
				`MFP_REG_CTRL: regRdData <= {9'h000, ctrl_q};
				`MFP_REG_STATE: regRdData <= {9'h000, otState_q, scHold_q, ocHold_q,
					ovHold_q, anyFault, ~driverEnable};
				default: regRdData <= 16'h0000;
			endcase
		end else begin
			regRdData <= 16'h0000;
		end
	end

endmodule
`default_nettype wire

// ---- design/mfp_consts.vh ----
// Purpose: Constants for the motor fault protection block
// Assumes: 20 MHz core clock, register port with one-cycle read latency
// Notes: Offsets are word indices on the plain register port
// ======================================================================
// Overview of operation
// - Supply low: fault out, driver off, auto resume
// - Supply low sets sticky flag, cleared by 0
// - Supply low flag set after power-up
// - Pump low flag set after power-up
// - Registers stay usable during supply lockout
// - Below reset threshold all registers reset
// - Level select picks one of two thresholds
// - Overvoltage: fault out, force asynchronous rectification
// - Overvoltage clear: release, resync after 60 us
// - Overvoltage sets sticky flag, cleared by 0
// - FET drop above limit past filter: overcurrent
// - Sense comparator trip is also overcurrent
// - Overcurrent: fault, driver off, 5 ms retry
// - Overcurrent sets sticky flag, cleared by 0
// - Pump low: fault, driver off, auto resume
// - Pump low sets sticky flag, cleared by 0
// - Pump short: all off, 5 s retry cycle
// - Pump short sets sticky flag, cleared by 0
// - Overtemp: fault, disable, sticky flag
// - Retry set: re-enable 5 s after cooling
// - Retry clear: latched off until reset
// - Other flags also clear on reset or power cycle
// - Fault output active low open drain
`ifndef MFP_CONSTS_VH
`define MFP_CONSTS_VH

// ======================================================================
// Register indices
`define MFP_REG_FAULT 3'h0
`define MFP_REG_CTRL 3'h1
`define MFP_REG_STATE 3'h2

// ======================================================================
// Fault register fields
`define MFP_FLT_SUPLOW 0
`define MFP_FLT_SUPOVER 1
`define MFP_FLT_OVERCUR 2
`define MFP_FLT_PUMPLOW 3
`define MFP_FLT_PUMPSHORT 4
`define MFP_FLT_OVERTEMP 5
`define MFP_FLT_RESET 6'h09

// ======================================================================
// Control register fields
`define MFP_CTL_SYNCRECT 0
`define MFP_CTL_OVLEVEL 1
`define MFP_CTL_RETRY 2
`define MFP_CTL_DROPLIM_LO 3
`define MFP_CTL_DROPLIM_HI 4
`define MFP_CTL_FILT_LO 5
`define MFP_CTL_FILT_HI 6
`define MFP_CTL_RESET 7'h00

// ======================================================================
// Timing
`define MFP_CLK_HZ 20000000
`define MFP_OV_RESYNC_US 60
`define MFP_OC_RETRY_MS 5
`define MFP_LONG_RETRY_S 5
`define MFP_OV_RESYNC_CYC ((`MFP_CLK_HZ / 1000000) * `MFP_OV_RESYNC_US)
`define MFP_OC_RETRY_CYC ((`MFP_CLK_HZ / 1000) * `MFP_OC_RETRY_MS)
`define MFP_LONG_RETRY_CYC (`MFP_CLK_HZ * `MFP_LONG_RETRY_S)
// Deglitch choices in cycles for filter setting 0..3
`define MFP_FILT_CYC0 20
`define MFP_FILT_CYC1 40
`define MFP_FILT_CYC2 80
`define MFP_FILT_CYC3 160

`endif

// ---- testbench/mfp_assertions.sv ----
// Purpose: Port checker for the fault protection block
// Assumes: Monitor levels held for several cycles
// Notes: Bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module mfp_fault_checker (
	input wire clk,
	input wire nrst,
	input wire supplyResetLow,
	input wire supplyUnder,
	input wire supplyOverLevel0,
	input wire supplyOverLevel1,
	input wire senseOverCur,
	input wire pumpLow,
	input wire pumpShort,
	input wire dieOverTemp,
	input wire faultFlagOutO,
	input wire faultFlagOutOe,
	input wire driverEnable,
	input wire pumpEnable,
	input wire syncRectifyActive
);
	// ==============================================================
	// Properties
	// Supply reset acts like the pin reset, so both mute checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst || supplyResetLow);
	a_pin_low: assert property (faultFlagOutO == 1'h0)
		else $error("Fault pin data not low");
	a_under_off: assert property (supplyUnder[*3] |-> faultFlagOutOe && !driverEnable)
		else $error("Undervoltage did not stop driver");
	a_pumplow_off: assert property (pumpLow[*3] |-> faultFlagOutOe && !driverEnable)
		else $error("Pump low did not stop driver");
	a_hot_off: assert property (dieOverTemp[*3] |-> faultFlagOutOe && !driverEnable)
		else $error("Overtemperature did not stop driver");
	a_ov_async: assert property ((supplyOverLevel0 && supplyOverLevel1)[*3]
		|-> faultFlagOutOe && !syncRectifyActive)
		else $error("Overvoltage kept synchronous rectification");
	a_short_off: assert property ($rose(pumpShort)
		|-> ##[1:3] (faultFlagOutOe && !driverEnable && !pumpEnable))
		else $error("Pump short did not stop pump and driver");
	a_sense_hold: assert property ($rose(senseOverCur) ##3 1
		|-> (faultFlagOutOe && !driverEnable)[*8])
		else $error("Sense trip hold too short");
	a_fault_or: assert property ((supplyUnder || pumpLow || pumpShort || dieOverTemp)[*3]
		|-> faultFlagOutOe)
		else $error("Fault pin not asserted");
	cover property ($rose(faultFlagOutOe));
	cover property ($rose(syncRectifyActive));
	cover property ($fell(pumpEnable));
endmodule
bind mfp_motor_fault_protection mfp_fault_checker mfp_fault_checker_i (.clk, .nrst,
	.supplyResetLow, .supplyUnder, .supplyOverLevel0, .supplyOverLevel1, .senseOverCur,
	.pumpLow, .pumpShort, .dieOverTemp, .faultFlagOutO, .faultFlagOutOe, .driverEnable,
	.pumpEnable, .syncRectifyActive);
`default_nettype wire

// ---- testbench/mfp_monitor_model.sv ----
// Purpose: Analog monitors and power stage stand-in
// Assumes: Stimulus changes just after a clock edge
// Notes: stim holds drop level, driven FETs, monitor events
`timescale 1ns/1ps
`default_nettype none
module mfp_monitor_model (
	input wire logic clk,
	input wire logic [15:0] stim,
	output logic [6:0] mon = 7'h00,
	output logic [5:0] fetEn = 6'h00,
	output logic [5:0] drop0,
	output logic [5:0] drop1,
	output logic [5:0] drop2,
	output logic [5:0] drop3
);
	// ==============================================================
	// Comparators
	always @(posedge clk) begin
		mon <= stim[6:0];
		fetEn <= stim[12:7];
	end
	// Drop only shows on a driven FET, as on a real stage
	assign drop0 = fetEn & {6{stim[15:13] > 3'h0}};
	assign drop1 = fetEn & {6{stim[15:13] > 3'h1}};
	assign drop2 = fetEn & {6{stim[15:13] > 3'h2}};
	assign drop3 = fetEn & {6{stim[15:13] > 3'h3}};
endmodule
`default_nettype wire

// ---- testbench/mfp_motor_fault_protection_tb_top.sv ----
// Purpose: Directed tests of the fault protection block
// Assumes: Shortened retry counts of 50 and 100 cycles
// Notes: Fault pin level resolved with a pull-up
`timescale 1ns/1ps
`default_nettype none
module mfp_motor_fault_protection_tb_top;
	logic clk, nrst, supRst, wrStb, rdStb;
	logic [2:0] regAddr;
	logic [15:0] regWrData, regRdData, stim;
	logic [6:0] mon;
	logic [5:0] fetEn, d0, d1, d2, d3;
	wire faultO, faultOe, drvEn, pumpEn, syncOn;
	wire faultPin = faultOe ? faultO : 1'h1;
	int badCount = 0;
	int comparisons = 0;
	// ==============================================================
	// Instances
	mfp_monitor_model mfp_monitor_model_i (.clk(clk), .stim(stim), .mon(mon), .fetEn(fetEn),
		.drop0(d0), .drop1(d1), .drop2(d2), .drop3(d3));
	mfp_motor_fault_protection #(.OC_RETRY_CYC(50), .LONG_RETRY_CYC(100))
	mfp_motor_fault_protection_i (.clk(clk), .nrst(nrst), .supplyResetLow(supRst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(wrStb), .regRdStb(rdStb),
		.regRdData(regRdData), .supplyUnder(mon[0]), .supplyOverLevel0(mon[1]),
		.supplyOverLevel1(mon[2]), .fetDropHigh0(d0), .fetDropHigh1(d1), .fetDropHigh2(d2),
		.fetDropHigh3(d3), .fetEnabled(fetEn), .senseOverCur(mon[3]), .pumpLow(mon[4]),
		.pumpShort(mon[5]), .dieOverTemp(mon[6]), .faultFlagOutO(faultO),
		.faultFlagOutOe(faultOe), .driverEnable(drvEn), .pumpEnable(pumpEn),
		.syncRectifyActive(syncOn));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// ==============================================================
	// Tasks
	task automatic finishTest();
		$display("comparisons=%0d mismatches=%0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			badCount++;
		end
	endtask
	task automatic ev(input logic [15:0] v);
		@(posedge clk);
		stim <= v;
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		wrStb <= 1'h1;
		@(posedge clk);
		wrStb <= 1'h0;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk);
		regAddr <= a;
		rdStb <= 1'h1;
		@(posedge clk);
		rdStb <= 1'h0;
		#1 chk(regRdData, exp);
	endtask
	// Pin level and driver enable, after the edge has settled
	task automatic os(input logic [1:0] exp);
		#1 chk({14'h0, faultPin, drvEn}, {14'h0, exp});
	endtask
	task automatic pk(input logic b, input logic e);
		#1 chk({15'h0, b}, {15'h0, e});
	endtask
	// ==============================================================
	// Tests
	initial begin
		#2000000;
		badCount++;
		finishTest();
	end
	initial begin
		nrst = 1'h0;
		supRst = 1'h0;
		wrStb = 1'h0;
		rdStb = 1'h0;
		regAddr = 3'h0;
		regWrData = 16'h0000;
		stim = 16'h0000;
		cyc(2);
		nrst <= 1'h1;
		rchk(3'h0, 16'h0009);
		rchk(3'h3, 16'h0000);
		wr(3'h0, 16'h003f);
		rchk(3'h0, 16'h0009);
		wr(3'h0, 16'h0000);
		rchk(3'h0, 16'h0000);
		ev(16'h0001);
		cyc(4);
		os(2'h0);
		wr(3'h1, 16'h0001);
		rchk(3'h1, 16'h0001);
		rchk(3'h0, 16'h0001);
		ev(16'h0000);
		cyc(4);
		os(2'h3);
		wr(3'h0, 16'h0000);
		for (int s = 0; s < 2; s++) begin
			wr(3'h1, {14'h0, s[0], 1'h1});
			ev(s ? 16'h0002 : 16'h0004);
			cyc(4);
			os(2'h3);
			ev(s ? 16'h0004 : 16'h0002);
			cyc(4);
			os(2'h1);
			pk(syncOn, 1'h0);
		end
		ev(16'h0006);
		cyc(4);
		ev(16'h0000);
		cyc(4);
		os(2'h3);
		cyc(1100);
		pk(syncOn, 1'h0);
		cyc(200);
		pk(syncOn, 1'h1);
		rchk(3'h0, 16'h0002);
		wr(3'h0, 16'h0000);
		ev(16'h0008);
		ev(16'h0000);
		cyc(4);
		os(2'h0);
		cyc(60);
		os(2'h3);
		rchk(3'h0, 16'h0004);
		// Undriven FET, a short glitch, then a real trip
		wr(3'h1, 16'h0000);
		wr(3'h0, 16'h0000);
		ev(16'h2000);
		cyc(40);
		ev(16'h2080);
		cyc(10);
		ev(16'h0000);
		rchk(3'h0, 16'h0000);
		ev(16'h2080);
		cyc(30);
		ev(16'h0000);
		rchk(3'h0, 16'h0004);
		cyc(60);
		wr(3'h1, 16'h0018);
		wr(3'h0, 16'h0000);
		ev(16'h2080);
		cyc(40);
		ev(16'h0000);
		rchk(3'h0, 16'h0000);
		wr(3'h0, 16'h0000);
		ev(16'h0010);
		cyc(4);
		os(2'h0);
		rchk(3'h0, 16'h0008);
		ev(16'h0000);
		cyc(4);
		os(2'h3);
		wr(3'h0, 16'h0000);
		ev(16'h0020);
		cyc(4);
		pk(pumpEn, 1'h0);
		ev(16'h0000);
		cyc(80);
		os(2'h0);
		cyc(40);
		os(2'h3);
		rchk(3'h0, 16'h0010);
		wr(3'h1, 16'h0004);
		wr(3'h0, 16'h0000);
		ev(16'h0040);
		cyc(4);
		os(2'h0);
		ev(16'h0000);
		cyc(80);
		os(2'h0);
		cyc(40);
		os(2'h3);
		rchk(3'h0, 16'h0020);
		wr(3'h1, 16'h0000);
		ev(16'h0040);
		cyc(4);
		ev(16'h0000);
		cyc(300);
		os(2'h0);
		@(posedge clk);
		nrst <= 1'h0;
		cyc(2);
		nrst <= 1'h1;
		cyc(2);
		os(2'h3);
		rchk(3'h0, 16'h0009);
		wr(3'h1, 16'h007f);
		rchk(3'h1, 16'h007f);
		wr(3'h0, 16'h0000);
		@(posedge clk);
		supRst <= 1'h1;
		cyc(2);
		supRst <= 1'h0;
		rchk(3'h0, 16'h0009);
		rchk(3'h1, 16'h0000);
		finishTest();
	end
endmodule
`default_nettype wire
